// ### core/pleb_pkg.sv
package pleb_pkg;
    // Register byte addresses
    localparam logic [3:0] PLEB_CTRL_ADDR = 4'h0;
    localparam logic [3:0] PLEB_DELAY_ADDR = 4'h4;
    localparam logic [3:0] PLEB_AUX_ADDR = 4'h8;
    localparam logic [3:0] PLEB_STAT_ADDR = 4'hC;
    // Control field positions
    localparam int PLEB_HRISE_BIT = 15;
    localparam int PLEB_HFALL_BIT = 14;
    localparam int PLEB_LRISE_BIT = 13;
    localparam int PLEB_LFALL_BIT = 12;
    localparam int PLEB_FLTEN_BIT = 11;
    localparam int PLEB_CLEN_BIT = 10;
    localparam int PLEB_SELH_BIT = 5;
    localparam int PLEB_SELL_BIT = 4;
    localparam int PLEB_HH_BIT = 3;
    localparam int PLEB_HL_BIT = 2;
    localparam int PLEB_LH_BIT = 1;
    localparam int PLEB_LL_BIT = 0;
    // Writable control bits; 9..6 unimplemented
    localparam logic [15:0] PLEB_CTRL_MASK = 16'hFC3F;
    localparam logic [15:0] PLEB_CTRL_RESET = 16'h0000;
    localparam int PLEB_DELAY_W = 12;
    localparam logic [11:0] PLEB_DELAY_RESET = 12'h000;
    localparam int PLEB_SEL_W = 4;
    localparam logic [3:0] PLEB_SEL_RESET = 4'h0;
    localparam int PLEB_SYNC_STAGES = 2;

    typedef struct packed {
        logic high_side_output;
        logic low_side_output;
    } pleb_pwm_t;

    typedef struct packed {
        logic fault;
        logic current_limit;
    } pleb_prot_t;
endpackage

// ### core/pleb_sync.sv
`timescale 1ns/1ns
module pleb_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    // First stage read only by the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule

// ### core/pleb_top.sv
`timescale 1ns/1ns
module pleb_top #(
    parameter int DELAY_W = pleb_pkg::PLEB_DELAY_W,
    parameter int NSRC = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire pleb_pkg::pleb_pwm_t pwm_i,
    input wire logic [NSRC-1:0] blank_src_i,
    input wire pleb_pkg::pleb_prot_t prot_i,
    output pleb_pkg::pleb_prot_t prot_o
);
    import pleb_pkg::*;

    // Duration is carried in one 16-bit register word
    if (DELAY_W < 1 || DELAY_W > 16) begin : g_bad_delay_w
        $error("DELAY_W out of range");
    end
    if (NSRC < 1 || NSRC > 16) begin : g_bad_nsrc
        $error("NSRC out of range");
    end

    logic [15:0] ctrl_reg;
    logic [DELAY_W-1:0] delay_reg;
    logic [PLEB_SEL_W-1:0] sel_reg;
    logic [DELAY_W-1:0] count_reg;
    logic [DELAY_W-1:0] count_next;
    pleb_pwm_t pwm_s;
    pleb_prot_t prot_s;
    logic [NSRC-1:0] src_s;
    pleb_pwm_t pwm_prev_reg;
    logic trig;
    logic window;
    logic sel_sig;
    logic state_blank;
    logic wb_req;
    logic [31:0] rd_data;

    // Outside signals are asynchronous to this clock
    pleb_sync #(.WIDTH(2)) u_sync_pwm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pwm_i),
        .q_o(pwm_s)
    );
    pleb_sync #(.WIDTH(2)) u_sync_prot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(prot_i),
        .q_o(prot_s)
    );
    pleb_sync #(.WIDTH(NSRC)) u_sync_src (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(blank_src_i),
        .q_o(src_s)
    );

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) r[7:0] = wd[7:0];
        if (sel[1]) r[15:8] = wd[15:8];
        return r;
    endfunction

    // Bus slave: ack one cycle after request, dropped the next
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= PLEB_CTRL_RESET;
        end else if (wb_req && wb_we_i && wb_adr_i == PLEB_CTRL_ADDR) begin
            ctrl_reg <= merge16(ctrl_reg, wb_dat_i, wb_sel_i) & PLEB_CTRL_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            delay_reg <= DELAY_W'(PLEB_DELAY_RESET);
        end else if (wb_req && wb_we_i && wb_adr_i == PLEB_DELAY_ADDR) begin
            delay_reg <= DELAY_W'(merge16(16'(delay_reg), wb_dat_i, wb_sel_i));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_reg <= PLEB_SEL_RESET;
        end else if (wb_req && wb_we_i && wb_adr_i == PLEB_AUX_ADDR && wb_sel_i[0]) begin
            sel_reg <= wb_dat_i[PLEB_SEL_W-1:0];
        end
    end

    always_comb begin
        case (wb_adr_i)
            PLEB_CTRL_ADDR: rd_data = {16'h0000, ctrl_reg};
            PLEB_DELAY_ADDR: rd_data = {16'h0000, 16'(delay_reg)};
            PLEB_AUX_ADDR: rd_data = {28'h0000000, sel_reg};
            PLEB_STAT_ADDR: rd_data = {16'h0000, 16'(count_reg)};
            default: rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_prev_reg <= '0;
        end else begin
            pwm_prev_reg <= pwm_s;
        end
    end

    // Edge detection on synchronised outputs
    assign trig = (ctrl_reg[PLEB_HRISE_BIT] && pwm_s.high_side_output
                   && !pwm_prev_reg.high_side_output)
        || (ctrl_reg[PLEB_HFALL_BIT] && !pwm_s.high_side_output
            && pwm_prev_reg.high_side_output)
        || (ctrl_reg[PLEB_LRISE_BIT] && pwm_s.low_side_output
            && !pwm_prev_reg.low_side_output)
        || (ctrl_reg[PLEB_LFALL_BIT] && !pwm_s.low_side_output
            && pwm_prev_reg.low_side_output);

    // Retrigger reloads the full duration
    always_comb begin
        if (trig) begin
            count_next = delay_reg;
        end else if (count_reg != '0) begin
            count_next = count_reg - DELAY_W'(1);
        end else begin
            count_next = count_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign window = (count_reg != '0);

    // Unused select codes read as a low signal
    assign sel_sig = (32'(sel_reg) < NSRC) ? src_s[sel_reg] : 1'b0;

    assign state_blank = (ctrl_reg[PLEB_SELH_BIT] && sel_sig)
        || (ctrl_reg[PLEB_SELL_BIT] && !sel_sig)
        || (ctrl_reg[PLEB_HH_BIT] && pwm_s.high_side_output)
        || (ctrl_reg[PLEB_HL_BIT] && !pwm_s.high_side_output)
        || (ctrl_reg[PLEB_LH_BIT] && pwm_s.low_side_output)
        || (ctrl_reg[PLEB_LL_BIT] && !pwm_s.low_side_output);

    // Gated outputs registered; one cycle behind the masks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_o <= '0;
        end else begin
            prot_o.fault <= prot_s.fault && !state_blank
                && !(window && ctrl_reg[PLEB_FLTEN_BIT]);
            prot_o.current_limit <= prot_s.current_limit && !state_blank
                && !(window && ctrl_reg[PLEB_CLEN_BIT]);
        end
    end

    // Enabled trigger edges as seen after synchronisation
    sequence s_hi_rise;
        ctrl_reg[PLEB_HRISE_BIT] && $rose(pwm_s.high_side_output);
    endsequence

    sequence s_hi_fall;
        ctrl_reg[PLEB_HFALL_BIT] && $fell(pwm_s.high_side_output);
    endsequence

    sequence s_lo_rise;
        ctrl_reg[PLEB_LRISE_BIT] && $rose(pwm_s.low_side_output);
    endsequence

    sequence s_lo_fall;
        ctrl_reg[PLEB_LFALL_BIT] && $fell(pwm_s.low_side_output);
    endsequence

    a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_reg[9:6] == 4'h0) else $error("Unimplemented bits set");
    a_hrise_load: assert property (@(posedge clk_i) disable iff (rst_i)
        s_hi_rise |=> count_reg == $past(delay_reg)) else $error("No reload on rise");
    a_hfall_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_reg[PLEB_HFALL_BIT] && !ctrl_reg[PLEB_HRISE_BIT]
        && !ctrl_reg[PLEB_LRISE_BIT] && !ctrl_reg[PLEB_LFALL_BIT]
        |=> count_reg <= $past(count_reg)) else $error("Disabled edge reloaded");
    a_lfall_load: assert property (@(posedge clk_i) disable iff (rst_i)
        s_lo_fall |=> count_reg == $past(delay_reg)) else $error("No reload on fall");
    a_fault_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        window && ctrl_reg[PLEB_FLTEN_BIT] |=> !prot_o.fault)
        else $error("Fault passed in window");
    a_cl_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        window && ctrl_reg[PLEB_CLEN_BIT] |=> !prot_o.current_limit)
        else $error("Limit passed in window");
    a_hh_blank: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_reg[PLEB_HH_BIT] && pwm_s.high_side_output
        |=> !prot_o.fault && !prot_o.current_limit) else $error("High blank failed");
    a_ll_blank: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_reg[PLEB_LL_BIT] && !pwm_s.low_side_output
        |=> !prot_o.fault && !prot_o.current_limit) else $error("Low blank failed");
    a_pass_thru: assert property (@(posedge clk_i) disable iff (rst_i)
        !window && !state_blank |=> prot_o == $past(prot_s))
        else $error("Input not passed");
    a_count_down: assert property (@(posedge clk_i) disable iff (rst_i)
        !trig && window |=> count_reg == $past(count_reg) - DELAY_W'(1))
        else $error("Counter stalled");

    a_hfall_load: assert property (@(posedge clk_i) disable iff (rst_i)
        s_hi_fall |=> count_reg == $past(delay_reg))
        else $error("No reload on high fall");

    a_lrise_load: assert property (@(posedge clk_i) disable iff (rst_i)
        s_lo_rise |=> count_reg == $past(delay_reg))
        else $error("No reload on low rise");

    a_idle_no_trig: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_reg[15:12] == 4'h0 && count_reg == '0 |=> count_reg == '0)
        else $error("Counter started without enable");

    a_retrig_load: assert property (@(posedge clk_i) disable iff (rst_i)
        trig |=> count_reg == $past(delay_reg))
        else $error("Retrigger did not reload");

    a_zero_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        trig && delay_reg == '0 |=> !window)
        else $error("Zero duration opened window");

    a_idle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !trig && !window |=> !window)
        else $error("Window opened without edge");

    a_fault_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_reg[PLEB_FLTEN_BIT] && !state_blank |=> prot_o.fault == $past(prot_s.fault))
        else $error("Fault blanked while disabled");

    a_cl_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_reg[PLEB_CLEN_BIT] && !state_blank
        |=> prot_o.current_limit == $past(prot_s.current_limit)) else $error("Limit blanked");

    a_selh_blank: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_reg[PLEB_SELH_BIT] && sel_sig |=> prot_o == 2'b00)
        else $error("Select high blank failed");

    a_sell_blank: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_reg[PLEB_SELL_BIT] && !sel_sig |=> prot_o == 2'b00)
        else $error("Select low blank failed");

    a_hl_blank: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_reg[PLEB_HL_BIT] && !pwm_s.high_side_output |=> prot_o == 2'b00)
        else $error("High-side low blank failed");

    a_lh_blank: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_reg[PLEB_LH_BIT] && pwm_s.low_side_output |=> prot_o == 2'b00)
        else $error("Low-side high blank failed");

    a_state_force: assert property (@(posedge clk_i) disable iff (rst_i)
        state_blank |=> prot_o == 2'b00)
        else $error("State blank not forced");

    a_sel_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req && wb_we_i && wb_adr_i == PLEB_AUX_ADDR && wb_sel_i[0]
        |=> sel_reg == $past(wb_dat_i[PLEB_SEL_W-1:0])) else $error("Select not written");

    a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req && wb_we_i && wb_adr_i == PLEB_CTRL_ADDR && wb_sel_i == 4'hF
        |=> ctrl_reg == ($past(wb_dat_i[15:0]) & PLEB_CTRL_MASK)) else $error("Ctrl write");

    a_delay_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req && wb_we_i && wb_adr_i == PLEB_DELAY_ADDR && wb_sel_i == 4'hF
        |=> delay_reg == DELAY_W'($past(wb_dat_i[15:0]))) else $error("Duration write");

    // Bus handshake: one registered ack per request
    a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req |=> wb_ack_o)
        else $error("Request not acknowledged");

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held too long");

    a_rd_data: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req && !wb_we_i |=> wb_dat_o == $past(rd_data))
        else $error("Read data not captured");

    a_rd_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wb_req && !wb_we_i) |=> $stable(wb_dat_o))
        else $error("Read data changed idle");

    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req && !wb_we_i && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h00000000)
        else $error("Unmapped read not zero");
endmodule

// ### dv/pleb_far_side.sv
`timescale 1ns/1ns
// Far side: PWM generator outputs, comparator inputs, blanking sources
module pleb_far_side (
    input wire logic clk_i,
    input wire pleb_pkg::pleb_pwm_t pwm_req_i,
    input wire pleb_pkg::pleb_prot_t prot_req_i,
    input wire logic [15:0] src_req_i,
    output pleb_pkg::pleb_pwm_t pwm_o,
    output pleb_pkg::pleb_prot_t prot_o,
    output logic [15:0] src_o
);
    import pleb_pkg::*;
    // Levels move only on clock edges, as the generator's own outputs do
    always @(posedge clk_i) begin
        pwm_o <= pwm_req_i;
        prot_o <= prot_req_i;
        src_o <= src_req_i;
    end
endmodule

// ### dv/pleb_top_test.sv
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module pleb_top_test;
    import pleb_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0, rd, dat_o;
    logic ack;
    pleb_pwm_t pwm_req = '0, pwm;
    pleb_prot_t prot_req = 2'b11, prot, prot_o;
    logic [15:0] src_req = 16'h0000, src;
    int errors = 0;
    int check_count = 0;
    pleb_pwm_t pre [4] = '{2'b00, 2'b10, 2'b00, 2'b01};
    pleb_pwm_t post [4] = '{2'b10, 2'b00, 2'b01, 2'b00};

    pleb_far_side far (.clk_i(clk_i), .pwm_req_i(pwm_req), .prot_req_i(prot_req),
        .src_req_i(src_req), .pwm_o(pwm), .prot_o(prot), .src_o(src));
    pleb_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .pwm_i(pwm), .blank_src_i(src), .prot_i(prot), .prot_o(prot_o));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            report_and_stop();
        end
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic ctrl(input logic [15:0] v);
        wb(1'b1, PLEB_CTRL_ADDR, {16'h0000, v});
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic report_and_stop();
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #(20 * 20000);
        errors++;
        report_and_stop();
    end

    initial begin
        pause(10);
        rst_i <= 1'b0;
        wb(1'b0, PLEB_CTRL_ADDR, 32'h0);
        `CHK(rd[15:0], PLEB_CTRL_RESET)
        wb(1'b0, PLEB_DELAY_ADDR, 32'h0);
        `CHK(rd[11:0], PLEB_DELAY_RESET)
        ctrl(16'hFFFF);
        wb(1'b0, PLEB_CTRL_ADDR, 32'h0);
        `CHK(rd[15:0], 16'hFC3F)
        // Unmapped address 2 decodes to nothing
        wb(1'b1, 4'h2, 32'hFFFF);
        wb(1'b0, 4'h2, 32'h0);
        `CHK(rd, 32'h0)
        wb(1'b1, PLEB_DELAY_ADDR, 32'h14);
        wb(1'b1, PLEB_AUX_ADDR, 32'h3);
        wb(1'b0, PLEB_AUX_ADDR, 32'h0);
        `CHK(rd[3:0], 4'h3)
        for (int i = 0; i < 4; i++) begin
            for (int en = 0; en < 2; en++) begin
                ctrl(16'h0000);
                pwm_req <= pre[i];
                pause(10);
                ctrl(16'h0C00 | (en ? (16'h1 << (15 - i)) : 16'h0));
                pwm_req <= post[i];
                pause(8);
                `CHK(prot_o, en ? 2'b00 : 2'b11)
                pause(40);
                `CHK(prot_o, 2'b11)
            end
        end
        for (int j = 0; j < 2; j++) begin
            ctrl(16'h0000);
            pwm_req <= 2'b00;
            pause(10);
            ctrl(j ? 16'h8400 : 16'h8800);
            pwm_req <= 2'b10;
            pause(8);
            `CHK(prot_o, j ? 2'b10 : 2'b01)
        end
        for (int b = 0; b < 6; b++) begin
            for (int lv = 0; lv < 2; lv++) begin
                ctrl(16'h1 << b);
                pwm_req <= lv ? 2'b11 : 2'b00;
                // Selected source 3 follows lv; the rest show the opposite
                src_req <= lv ? 16'h0008 : 16'hFFF7;
                pause(8);
                `CHK(prot_o, ((b % 2) == lv) ? 2'b00 : 2'b11)
            end
        end
        ctrl(16'h0000);
        prot_req <= 2'b00;
        pause(8);
        `CHK(prot_o, 2'b00)
        prot_req <= 2'b10;
        pause(8);
        `CHK(prot_o, 2'b10)
        wb(1'b0, PLEB_STAT_ADDR, 32'h0);
        `CHK(rd[11:0], 12'h000)
        report_and_stop();
    end
endmodule
